//--- mac_datapath.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - 100 Mb/s loopback: receive valid rises within 240 ns of transmit enable.
// - Entering 100 Mb/s loopback blanks receive outputs for up to 550 us.
// - 10 Mb/s loopback: receive valid rises within 2 us of transmit enable.
// - Transmit dibit and enable are sampled on the reference clock rise.
// - Transmit data reaches the line 11 bit times after sampling.
// - Carrier/valid rises 18.5 (copper) or 9 (fiber) bit times after start.
// - Carrier/valid falls 27 (copper) or 17 (fiber) bit times after end.
// - Receive dibit and error emerge 38 (copper) or 27 (fiber) bit times late.
// - Carrier/valid rises at once; falls on a reference clock edge, or at once in isolate or dead time.
// - A separate receive valid output is updated on reference clock edges.
// - Isolate exits within 100 us after the isolate control clears.
// - Clock to MAC follows the reference: half rate in MII, full in RMII.
// - One bit time at 100 Mb/s is 10 ns.
module mac_datapath
  import latency_pkg::*;
#(
  parameter int DEAD_CYCLES = DEAD_TIME_CYC,
  parameter int ISO_CYCLES = ISO_EXIT_CYC,
  parameter int DLY_DEPTH = 64,
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ref_clk_in,
  input wire logic tx_en_in,
  input wire logic [1:0] txd_in,
  input wire latency_pkg::stage_t line_rx_in,
  input wire logic line_tx_ready_in,
  input wire logic loopback_in,
  input wire logic speed_100_in,
  input wire logic fiber_in,
  input wire logic rmii_mode_in,
  input wire logic isolate_in,
  output logic [1:0] line_tx_dibit_out,
  output logic line_tx_valid_out,
  output logic tx_ready_out,
  output latency_pkg::mac_rx_t rx_out,
  output logic mac_clk_out,
  output logic isolated_out,
  output logic rx_dead_out
);
  import latency_pkg::*;

  localparam int TW = $clog2(DLY_DEPTH);
  localparam int PW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CW = 32;

  // Pin synchronisers: ref, tx_en, txd
  logic [3:0] sync1_r, sync2_r;
  logic ref_d_r;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      ref_d_r <= 1'b0;
    end else begin
      sync1_r <= {ref_clk_in, tx_en_in, txd_in};
      sync2_r <= sync1_r;
      ref_d_r <= sync2_r[3];
    end
  end

  logic ref_rise;
  logic tx_en_s;
  logic [1:0] txd_s;
  assign ref_rise = sync2_r[3] & ~ref_d_r;
  assign tx_en_s = sync2_r[2];
  assign txd_s = sync2_r[1:0];

  // Mode and timer state
  logic iso_r, iso_nxt, lb_d_r, lb_d_nxt, div_r, div_nxt;
  logic mclk_r, mclk_nxt;
  logic [CW-1:0] iso_cnt_r, iso_cnt_nxt, dead_cnt_r, dead_cnt_nxt;
  // Dead flag is registered so the output comes straight from a flop
  logic dead, dead_r, dead_nxt;
  assign dead = dead_r;

  always_comb begin
    iso_nxt = iso_r;
    iso_cnt_nxt = iso_cnt_r;
    if (isolate_in) begin
      iso_nxt = 1'b1;
      iso_cnt_nxt = CW'(ISO_CYCLES);
    end else if (iso_r) begin
      if (iso_cnt_r <= 1) begin
        iso_nxt = 1'b0;
        iso_cnt_nxt = '0;
      end else begin
        iso_cnt_nxt = iso_cnt_r - 1'b1;
      end
    end
    lb_d_nxt = loopback_in;
    dead_cnt_nxt = dead ? dead_cnt_r - 1'b1 : dead_cnt_r;
    // Only the 100 Mb/s descrambler needs resync time
    if (loopback_in && !lb_d_r && speed_100_in) begin
      dead_cnt_nxt = CW'(DEAD_CYCLES);
    end
    dead_nxt = (dead_cnt_nxt != '0);
    div_nxt = ref_rise ? ~div_r : div_r;
    // Sync stages add about 16 ns of lag to the reference
    mclk_nxt = rmii_mode_in ? sync2_r[3] : div_r;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      iso_r <= 1'b1;
      iso_cnt_r <= '0;
      lb_d_r <= 1'b0;
      dead_cnt_r <= '0;
      dead_r <= 1'b0;
      div_r <= 1'b0;
      mclk_r <= 1'b0;
    end else begin
      iso_r <= iso_nxt;
      iso_cnt_r <= iso_cnt_nxt;
      lb_d_r <= lb_d_nxt;
      dead_cnt_r <= dead_cnt_nxt;
      dead_r <= dead_nxt;
      div_r <= div_nxt;
      mclk_r <= mclk_nxt;
    end
  end

  // Delay lines; entry 0 is one cycle old
  stage_t tx_sr_r [DLY_DEPTH];
  stage_t rx_sr_r [DLY_DEPTH];
  stage_t tx_src, rx_src;

  always_comb begin
    tx_src = STAGE_IDLE;
    tx_src.valid = ref_rise & tx_en_s & ~iso_r & ~loopback_in;
    tx_src.carrier = tx_src.valid;
    tx_src.dibit = txd_s;
    if (iso_r) begin
      rx_src = STAGE_IDLE;
    end else if (loopback_in) begin
      rx_src.carrier = tx_en_s;
      rx_src.valid = ref_rise & tx_en_s;
      rx_src.dibit = txd_s;
      rx_src.er = 1'b0;
    end else begin
      rx_src = line_rx_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < DLY_DEPTH; i++) begin
        tx_sr_r[i] <= STAGE_IDLE;
        rx_sr_r[i] <= STAGE_IDLE;
      end
    end else begin
      tx_sr_r[0] <= tx_src;
      rx_sr_r[0] <= rx_src;
      for (int i = 1; i < DLY_DEPTH; i++) begin
        tx_sr_r[i] <= tx_sr_r[i-1];
        rx_sr_r[i] <= rx_sr_r[i-1];
      end
    end
  end

  // Tap selection by mode
  logic [TW-1:0] on_tap, off_tap, lat_tap;
  stage_t tx_tap;
  always_comb begin
    if (loopback_in) begin
      on_tap = TW'(LB_CYC - 1);
      off_tap = TW'(LB_CYC - 1);
      lat_tap = TW'(LB_CYC - 1);
    end else if (fiber_in) begin
      on_tap = TW'(CRS_ON_FX_CYC - 1);
      off_tap = TW'(CRS_OFF_FX_CYC - 1);
      lat_tap = TW'(RX_LAT_FX_CYC - 1);
    end else begin
      on_tap = TW'(CRS_ON_TX_CYC - 1);
      off_tap = TW'(CRS_OFF_TX_CYC - 1);
      lat_tap = TW'(RX_LAT_TX_CYC - 1);
    end
    tx_tap = tx_sr_r[TW'(TX_LAT_CYC - 1)];
  end

  // Receive outputs
  mac_rx_t rx_r, rx_nxt;
  stage_t hold_r, hold_nxt;
  always_comb begin
    rx_nxt = rx_r;
    hold_nxt = hold_r;
    if (rx_sr_r[lat_tap].valid) begin
      hold_nxt = rx_sr_r[lat_tap];
    end
    if (dead || iso_r) begin
      rx_nxt = MAC_RX_IDLE;
      hold_nxt = STAGE_IDLE;
    end else begin
      // Rise on any system edge keeps latency low
      if (!rx_r.crs_dv && rx_sr_r[on_tap].carrier) begin
        rx_nxt.crs_dv = 1'b1;
      end else if (rx_r.crs_dv && ref_rise && !rx_sr_r[off_tap].carrier) begin
        rx_nxt.crs_dv = 1'b0;
      end
      if (ref_rise) begin
        rx_nxt.rx_dv = rx_sr_r[lat_tap].carrier;
        rx_nxt.dibit = hold_nxt.dibit;
        rx_nxt.er = hold_nxt.er & rx_sr_r[lat_tap].carrier;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rx_r <= MAC_RX_IDLE;
      hold_r <= STAGE_IDLE;
    end else begin
      rx_r <= rx_nxt;
      hold_r <= hold_nxt;
    end
  end

  // Two-entry transmit buffer toward the line
  logic [1:0] buf_r [BUF_DEPTH];
  logic [1:0] buf_nxt [BUF_DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [PW:0] cnt_r, cnt_nxt;
  logic [1:0] ltx_r, ltx_nxt;
  logic lv_r, lv_nxt, rdy_r, rdy_nxt;
  logic push, pop;

  always_comb begin
    buf_nxt = buf_r;
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    ltx_nxt = ltx_r;
    lv_nxt = lv_r;
    // Output stage refills when empty or when the line takes it
    pop = (cnt_r != '0) && (!lv_r || line_tx_ready_in);
    push = tx_tap.valid && (cnt_r != (PW+1)'(BUF_DEPTH));
    if (lv_r && line_tx_ready_in) begin
      lv_nxt = 1'b0;
    end
    if (pop) begin
      ltx_nxt = buf_r[rp_r];
      lv_nxt = 1'b1;
      rp_nxt = (rp_r == PW'(BUF_DEPTH - 1)) ? '0 : rp_r + 1'b1;
    end
    if (push) begin
      buf_nxt[wp_r] = tx_tap.dibit;
      wp_nxt = (wp_r == PW'(BUF_DEPTH - 1)) ? '0 : wp_r + 1'b1;
    end
    cnt_nxt = cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    rdy_nxt = (cnt_nxt < (PW+1)'(BUF_DEPTH));
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_r[i] <= 2'h0;
      end
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      ltx_r <= 2'h0;
      lv_r <= 1'b0;
      rdy_r <= 1'b1;
    end else begin
      buf_r <= buf_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      ltx_r <= ltx_nxt;
      lv_r <= lv_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  assign line_tx_dibit_out = ltx_r;
  assign line_tx_valid_out = lv_r;
  assign tx_ready_out = rdy_r;
  assign rx_out = rx_r;
  assign mac_clk_out = mclk_r;
  assign isolated_out = iso_r;
  assign rx_dead_out = dead;

endmodule : mac_datapath
`default_nettype wire

//--- latency_pkg.sv
package latency_pkg;

  // Clock and bit-time base
  localparam int CLK_PERIOD_NS = 8;
  localparam int BIT_TIME_NS = 10;
  localparam int TENTHS = 10;

  // Typical latencies in tenths of a bit time
  localparam int TX_LAT_TBIT = 110;
  localparam int CRS_ON_TX_TBIT = 185;
  localparam int CRS_ON_FX_TBIT = 90;
  localparam int CRS_OFF_TX_TBIT = 270;
  localparam int CRS_OFF_FX_TBIT = 170;
  localparam int RX_LAT_TX_TBIT = 380;
  localparam int RX_LAT_FX_TBIT = 270;

  localparam int TX_LAT_CYC = TX_LAT_TBIT * BIT_TIME_NS
                              / (TENTHS * CLK_PERIOD_NS);
  localparam int CRS_ON_TX_CYC = CRS_ON_TX_TBIT * BIT_TIME_NS
                                 / (TENTHS * CLK_PERIOD_NS);
  localparam int CRS_ON_FX_CYC = CRS_ON_FX_TBIT * BIT_TIME_NS
                                 / (TENTHS * CLK_PERIOD_NS);
  localparam int CRS_OFF_TX_CYC = CRS_OFF_TX_TBIT * BIT_TIME_NS
                                  / (TENTHS * CLK_PERIOD_NS);
  localparam int CRS_OFF_FX_CYC = CRS_OFF_FX_TBIT * BIT_TIME_NS
                                  / (TENTHS * CLK_PERIOD_NS);
  localparam int RX_LAT_TX_CYC = RX_LAT_TX_TBIT * BIT_TIME_NS
                                 / (TENTHS * CLK_PERIOD_NS);
  localparam int RX_LAT_FX_CYC = RX_LAT_FX_TBIT * BIT_TIME_NS
                                 / (TENTHS * CLK_PERIOD_NS);

  // Loopback limits; the internal delay takes half the 100 Mb/s budget,
  // leaving room for input sync and the wait for a reference edge
  localparam int LB100_MAX_NS = 240;
  localparam int LB10_MAX_NS = 2000;
  localparam int LB100_MAX_CYC = LB100_MAX_NS / CLK_PERIOD_NS;
  localparam int LB10_MAX_CYC = LB10_MAX_NS / CLK_PERIOD_NS;
  localparam int LB_CYC = LB100_MAX_CYC / 2;

  // Long intervals
  localparam int DEAD_TIME_US = 550;
  localparam int ISO_EXIT_US = 100;
  localparam int NS_PER_US = 1000;
  localparam int DEAD_TIME_CYC = DEAD_TIME_US * NS_PER_US / CLK_PERIOD_NS;
  localparam int ISO_EXIT_CYC = ISO_EXIT_US * NS_PER_US / CLK_PERIOD_NS;

  // Reference clock (reduced MII)
  localparam int REF_PERIOD_NS = 20;

  // Delay-line stage, also used for line-side receive input
  typedef struct packed {
    logic carrier;
    logic valid;
    logic [1:0] dibit;
    logic er;
  } stage_t;

  typedef struct packed {
    logic en;
    logic [1:0] dibit;
  } line_tx_t;

  typedef struct packed {
    logic crs_dv;
    logic rx_dv;
    logic [1:0] dibit;
    logic er;
  } mac_rx_t;

  localparam stage_t STAGE_IDLE = '0;
  localparam mac_rx_t MAC_RX_IDLE = '0;

endpackage : latency_pkg

//--- mac_datapath_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mac_datapath_chk
  import latency_pkg::*;
#(
  parameter int ISO_CYCLES = 50
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ref_clk_in,
  input wire logic tx_en_in,
  input wire latency_pkg::stage_t line_rx_in,
  input wire logic line_tx_ready_in,
  input wire logic loopback_in,
  input wire logic speed_100_in,
  input wire logic fiber_in,
  input wire logic rmii_mode_in,
  input wire logic isolate_in,
  input wire logic [1:0] line_tx_dibit_out,
  input wire logic line_tx_valid_out,
  input wire latency_pkg::mac_rx_t rx_out,
  input wire logic mac_clk_out,
  input wire logic isolated_out,
  input wire logic rx_dead_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  int low_r;
  int low_nxt;
  always_comb low_nxt = isolate_in ? 0 : low_r + 1;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) low_r <= 0;
    else low_r <= low_nxt;
  end
  sequence s_copper_start;
    $rose(line_rx_in.carrier) && speed_100_in && !fiber_in &&
      !loopback_in && !isolated_out && !rx_dead_out;
  endsequence
  sequence s_loop_start;
    $rose(tx_en_in) && loopback_in && speed_100_in &&
      !isolated_out && !rx_dead_out;
  endsequence
  a_iso_quiet: assert property (
    isolated_out [*2] |-> rx_out == MAC_RX_IDLE) else $error("rx in isolate");
  a_dead_quiet: assert property (
    rx_dead_out [*2] |-> rx_out == MAC_RX_IDLE) else $error("rx in dead time");
  a_iso_exit_bound: assert property (
    low_r > ISO_CYCLES + 2 |-> !isolated_out) else $error("isolate stuck");
  a_tx_hold: assert property (
    line_tx_valid_out && !line_tx_ready_in |=>
      line_tx_valid_out && $stable(line_tx_dibit_out)) else $error("tx lost");
  a_crs_on: assert property (
    s_copper_start |-> ##[1:26] rx_out.crs_dv) else $error("crs_dv late");
  a_crs_off: assert property (
    $fell(line_rx_in.carrier) && !fiber_in && !loopback_in |->
      ##[1:60] !rx_out.crs_dv) else $error("crs_dv stuck");
  a_loop_dv: assert property (
    s_loop_start |-> ##[1:52] rx_out.rx_dv) else $error("loopback late");
  a_clk_rmii: assert property (
    $rose(ref_clk_in) && rmii_mode_in |-> ##[2:7] $rose(mac_clk_out))
    else $error("mac clock lost");
endmodule : mac_datapath_chk
bind mac_datapath mac_datapath_chk #(.ISO_CYCLES(ISO_CYCLES)) chk_u (.*);
`default_nettype wire

//--- mac_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module mac_tx_model (
  input wire logic ref_clk_in,
  input wire logic go_in,
  input wire logic [3:0] count_in,
  output logic tx_en_out,
  output logic [1:0] txd_out
);
  int sent = 0;
  initial tx_en_out = 1'b0;
  initial txd_out = 2'h0;
  // Drive just after the rise so the next rise samples settled data
  always @(posedge ref_clk_in) begin
    // Two ns keeps the change off the system clock's sampling edges
    #2;
    if (go_in && sent < int'(count_in)) begin
      tx_en_out <= 1'b1;
      txd_out <= 2'(sent);
      sent <= sent + 1;
    end else begin
      tx_en_out <= 1'b0;
      // Idle data keeps moving so stale dibits never pass for real ones
      txd_out <= ~txd_out;
      if (!go_in) sent <= 0;
    end
  end
endmodule : mac_tx_model
`default_nettype wire

//--- mac_datapath_test.sv
`timescale 1ns/1ps
`default_nettype none
module mac_datapath_test;
  import latency_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ref_clk = 1'b0;
  logic go = 1'b0;
  logic ready = 1'b1;
  logic loopback = 1'b0;
  logic speed = 1'b1;
  logic fiber = 1'b0;
  logic iso = 1'b0;
  logic rmii = 1'b1;
  logic mclk;
  logic [3:0] count = 4'h4;
  stage_t line_rx = STAGE_IDLE;
  logic tx_en, tx_ready, tx_valid, isolated, dead;
  logic [1:0] txd, tx_dibit;
  mac_rx_t rx;
  logic [6:0] conds;
  int miscompares = 0;
  int check_count = 0;
  assign conds = {tx_en, rx.rx_dv, !dead, !isolated, !rx.crs_dv, rx.crs_dv,
                  tx_valid};
  always #4 clk_in = ~clk_in;
  initial begin
    #3;
    forever #80 ref_clk = ~ref_clk;
  end
  mac_tx_model mac_u (.ref_clk_in(ref_clk), .go_in(go), .count_in(count),
    .tx_en_out(tx_en), .txd_out(txd));
  mac_datapath #(.DEAD_CYCLES(200), .ISO_CYCLES(50)) dut_u (
    .clk_in(clk_in), .rst_in(rst_in), .ref_clk_in(ref_clk),
    .tx_en_in(tx_en), .txd_in(txd), .line_rx_in(line_rx),
    .line_tx_ready_in(ready), .loopback_in(loopback), .speed_100_in(speed),
    .fiber_in(fiber), .rmii_mode_in(rmii), .isolate_in(iso),
    .line_tx_dibit_out(tx_dibit), .line_tx_valid_out(tx_valid),
    .tx_ready_out(tx_ready), .rx_out(rx), .mac_clk_out(mclk),
    .isolated_out(isolated), .rx_dead_out(dead));
  task automatic report_and_stop();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s exp %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic tick(int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick
  task automatic await(int sel, int lim, output int n);
    n = 0;
    while (conds[sel] !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    if (n >= lim) begin
      miscompares++;
      report_and_stop();
    end
  endtask : await
  task automatic test_iso();
    int n;
    iso = 1'b1;
    tick(4);
    check("isolated", 8'(isolated), 8'h01);
    iso = 1'b0;
    await(3, 200, n);
    check("iso exit", 8'(n <= 53), 8'h01);
    $display("test_iso done");
  endtask : test_iso
  task automatic test_tx();
    int n;
    go = 1'b1;
    await(6, 40, n);
    @(posedge ref_clk);
    await(0, 40, n);
    check("tx latency", 8'(n >= 13 && n <= 21), 8'h01);
    for (int i = 0; i < 4; i++) begin
      await(0, 40, n);
      check("tx dibit", 8'(tx_dibit), 8'(i % 4));
      tick(1);
    end
    go = 1'b0;
    tick(45);
    ready = 1'b0;
    count = 4'h6;
    go = 1'b1;
    tick(200);
    check("tx full", 8'(tx_ready), 8'h00);
    check("tx held", 8'(tx_dibit), 8'h00);
    ready = 1'b1;
    go = 1'b0;
    tick(100);
    check("tx drained", 8'(tx_ready), 8'h01);
    $display("test_tx done");
  endtask : test_tx
  task automatic test_rx(logic fx, int on_max, int off_max, int lat_max);
    int n;
    int m;
    fiber = fx;
    line_rx = 5'h1C;
    tick(1);
    line_rx.valid = 1'b0;
    await(1, 40, n);
    check("crs on", 8'(n <= on_max), 8'h01);
    await(5, 100, m);
    check("rx latency", 8'(n + m <= lat_max), 8'h01);
    check("rx dibit", 8'({rx.dibit, rx.er}), 8'h04);
    line_rx.carrier = 1'b0;
    await(2, 80, n);
    check("crs off", 8'(n <= off_max), 8'h01);
    tick(60);
    $display("test_rx done");
  endtask : test_rx
  task automatic test_loop(logic spd, int dv_max);
    int n;
    speed = spd;
    loopback = 1'b1;
    tick(2);
    check("dead start", 8'(dead), 8'(spd));
    await(4, 210, n);
    check("dead len", 8'(n <= 202), 8'h01);
    count = 4'h2;
    go = 1'b1;
    await(6, 40, n);
    @(posedge ref_clk);
    await(5, 300, n);
    check("loop dv", 8'(n <= dv_max), 8'h01);
    go = 1'b0;
    loopback = 1'b0;
    tick(60);
    $display("test_loop done");
  endtask : test_loop
  task automatic test_clk(logic mode, int span);
    int rises;
    logic prev;
    rises = 0;
    // Switch away from a reference rise so no clock edge is in flight
    @(negedge ref_clk);
    tick(1);
    rmii = mode;
    tick(60);
    prev = mclk;
    for (int i = 0; i < span; i++) begin
      tick(1);
      if (mclk && !prev) rises++;
      prev = mclk;
    end
    check("clk rises", 8'(rises), 8'h02);
    $display("test_clk done");
  endtask : test_clk
  initial begin
    tick(16);
    rst_in = 1'b0;
    tick(4);
    test_iso();
    test_tx();
    test_rx(1'b0, 26, 57, 72);
    test_rx(1'b1, 13, 45, 58);
    test_loop(1'b1, 30);
    test_loop(1'b0, 250);
    test_clk(1'b0, 80);
    test_clk(1'b1, 40);
    report_and_stop();
  end
endmodule : mac_datapath_test
`default_nettype wire
